/* design/pec_crc8.sv */
// Bit-serial CRC-8 for packet error checking
`timescale 1ns/1ps
module pec_crc8
	import pmod_status_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	input  wire logic       i_clear,
	input  wire logic       i_shift,
	input  wire logic       i_bit,
	output logic      [7:0] o_crc
);
	logic [7:0] crc_q;
	logic [7:0] crc_d;

	always_comb begin
		crc_d = crc_q;
		if (i_clear) begin
			crc_d = PEC_INIT;
		end else if (i_shift) begin
			crc_d = {crc_q[6:0], 1'b0} ^ ((crc_q[7] ^ i_bit) ? PEC_POLY : 8'h00);
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			crc_q <= PEC_INIT;
		end else begin
			crc_q <= crc_d;
		end
	end

	assign o_crc = crc_q;
endmodule : pec_crc8

/* design/pmod_status_pkg.sv */
// Constants and carrier types for the power module status register block
package pmod_status_pkg;

	// ------------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------------
	localparam logic [7:0] CMD_RUN_CTRL       = 8'h01;
	localparam logic [7:0] CMD_ENABLE_CFG     = 8'h02;
	localparam logic [7:0] CMD_FAULT_CLEAR    = 8'h03;
	localparam logic [7:0] CMD_CURRENT_STATUS = 8'h7B;
	localparam logic [7:0] CMD_THERMAL_STATUS = 8'h7D;
	localparam logic [7:0] CMD_COMM_STATUS    = 8'h7E;
	localparam logic [7:0] CMD_VIN_FLOOR      = 8'hA0;
	localparam logic [7:0] CMD_VOUT_FLOOR     = 8'hA4;
	localparam logic [7:0] CMD_MODULE_ID      = 8'hD0;

	// ------------------------------------------------------------------
	// Status flag masks
	// ------------------------------------------------------------------
	localparam logic [7:0] IOUT_OC_FAULT_M = 8'h80;
	localparam logic [7:0] IOUT_OC_WARN_M  = 8'h20;
	localparam logic [7:0] TEMP_OT_FAULT_M = 8'h80;
	localparam logic [7:0] TEMP_OT_WARN_M  = 8'h40;
	localparam logic [7:0] CML_BAD_CMD_M   = 8'h80;
	localparam logic [7:0] CML_BAD_DATA_M  = 8'h40;
	localparam logic [7:0] CML_PEC_M       = 8'h20;
	localparam logic [7:0] CML_OTHER_M     = 8'h02;
	localparam logic [7:0] IOUT_MASK       = IOUT_OC_FAULT_M | IOUT_OC_WARN_M;
	localparam logic [7:0] TEMP_MASK       = TEMP_OT_FAULT_M | TEMP_OT_WARN_M;
	localparam logic [7:0] CML_MASK        = CML_BAD_CMD_M | CML_BAD_DATA_M | CML_PEC_M
	                                       | CML_OTHER_M;
	localparam logic [7:0] STATUS_RST      = 8'h00;

	// ------------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------------
	localparam logic [7:0] RUN_CTRL_WMASK = 8'hBC;
	localparam logic [7:0] RUN_CTRL_RST   = 8'h00;
	localparam logic [7:0] EN_CFG_WMASK   = 8'h1E;
	localparam logic [7:0] EN_CFG_RST     = 8'h17;
	localparam int         RUN_ON_BIT     = 7;
	localparam int         ENC_PU_BIT     = 4;
	localparam int         ENC_CMD_BIT    = 3;
	localparam int         ENC_CPR_BIT    = 2;
	localparam int         ENC_POL_BIT    = 1;

	// ------------------------------------------------------------------
	// Fixed words
	// ------------------------------------------------------------------
	localparam logic [4:0]  VIN_FLOOR_EXP   = 5'h1E;
	localparam logic [10:0] VIN_FLOOR_MANT  = 11'h00C;
	localparam logic [4:0]  VOUT_FLOOR_EXP  = 5'h16;
	localparam logic [10:0] VOUT_FLOOR_MANT = 11'h266;
	localparam logic [15:0] VIN_FLOOR_WORD  = {VIN_FLOOR_EXP, VIN_FLOOR_MANT};
	localparam logic [15:0] VOUT_FLOOR_WORD = {VOUT_FLOOR_EXP, VOUT_FLOOR_MANT};
	localparam logic [1:0]  ID_LOW_RSVD     = 2'h2;
	localparam logic [7:0]  READ_FILL       = 8'hFF;

	// ------------------------------------------------------------------
	// Serial framing
	// ------------------------------------------------------------------
	localparam logic [3:0] BYTE_BITS      = 4'h8;
	localparam logic [2:0] LEN_BYTE_WRITE = 3'h2;
	localparam logic [2:0] LEN_SEND_BYTE  = 3'h1;
	localparam logic [2:0] BYTE_N_MAX     = 3'h7;
	localparam logic [1:0] CAP_DLY        = 2'h2;
	localparam logic [7:0] PEC_POLY       = 8'h07;
	localparam logic [7:0] PEC_INIT       = 8'h00;

	typedef struct packed {
		logic oc_fault;
		logic oc_warn;
		logic ot_fault;
		logic ot_warn;
	} fault_in_s;

	typedef struct packed {
		logic [7:0] run_ctrl;
		logic [7:0] en_cfg;
	} ctrl_out_s;

endpackage : pmod_status_pkg

/* design/power_module_status_regs.sv */
// Status, limit and identification registers behind the serial management bus
//
// Functional notes
// (RULE1) Current status: bit7 fault, bit5 warning, reset zero
// (RULE2) Thermal status: bit7 fault, bit6 warning, reset zero
// (RULE3) Comm status: bad command bits7,6; other bit1
// (RULE4) Packet check mismatch sets comm status bit5
// (RULE5) Input floor reads exponent -2, mantissa 12
// (RULE6) Output floor reads exponent -10, mantissa 614
// (RULE7) ID low byte: type [7:2], reserved 10
// (RULE8) ID high byte bits 1:0 hold maker id
// (RULE9) ID high byte carries per-unit revision number
// (RULE10) Command 01 run/margin control, read and write
// (RULE11) Command 02 selects how pin/bus enable output
// (RULE12) Status bit one means condition flagged
// (RULE13) Command 03 clears faults and releases alert
// (RULE14) Undefined status bits read zero, ignore writes
`timescale 1ns/1ps
module power_module_status_regs
	import pmod_status_pkg::*;
#(
	parameter logic [6:0] BUS_ADDR    = 7'h40,
	parameter logic [5:0] MODULE_TYPE = 6'h2D, // Arbitrary value
	parameter logic [1:0] MFR_ID      = 2'h3   // Arbitrary value
) (
	input  wire logic      I_REF_CLK,
	input  wire logic      I_RST_N,
	input  wire logic      I_SCL,
	input  wire logic      I_SDA,
	input  wire logic      I_ONOFF_PIN,
	input  wire fault_in_s I_FAULTS,
	input  wire logic [5:0] I_MODULE_REV,
	output logic           O_SDA,
	output logic           O_SDA_OE,
	output logic           O_ALERT,
	output logic           O_ALERT_OE,
	output ctrl_out_s      O_CTRL,
	output logic           O_OUTPUT_EN
);
	// ------------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------------
	localparam int SYNC_W = 13;
	// Bus lines idle high, so no false edge follows reset
	localparam logic [SYNC_W-1:0] SYNC_RST = {2'h3, {(SYNC_W-2){1'b0}}};
	logic [SYNC_W-1:0] sync1_q;
	logic [SYNC_W-1:0] sync2_q;
	logic              scl_prev_q;
	logic              sda_prev_q;
	logic              scl_s;
	logic              sda_s;
	logic              pin_s;
	fault_in_s         flt_s;
	logic [5:0]        rev_s;

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			sync1_q    <= SYNC_RST;
			sync2_q    <= SYNC_RST;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			sync1_q    <= {I_SCL, I_SDA, I_ONOFF_PIN, I_FAULTS, I_MODULE_REV};
			sync2_q    <= sync1_q;
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	assign {scl_s, sda_s, pin_s, flt_s, rev_s} = sync2_q;

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ------------------------------------------------------------------
	// Read data decode
	// ------------------------------------------------------------------
	function automatic logic [8:0] read_byte(
		input logic [7:0]  cmd,
		input logic [1:0]  idx,
		input logic [7:0]  run,
		input logic [7:0]  cfg,
		input logic [7:0]  iout,
		input logic [7:0]  temp,
		input logic [7:0]  cml,
		input logic [15:0] id
	);
		logic [15:0] word;
		logic        is_word;
		logic        ok;
		logic [7:0]  val;
		word    = 16'h0000;
		is_word = 1'b0;
		ok      = 1'b1;
		val     = READ_FILL;
		case (cmd)
			CMD_RUN_CTRL:       val = run;
			CMD_ENABLE_CFG:     val = cfg;
			CMD_CURRENT_STATUS: val = iout;
			CMD_THERMAL_STATUS: val = temp;
			CMD_COMM_STATUS:    val = cml;
			CMD_VIN_FLOOR: begin
				word    = VIN_FLOOR_WORD; // RULE5
				is_word = 1'b1;
			end
			CMD_VOUT_FLOOR: begin
				word    = VOUT_FLOOR_WORD; // RULE6
				is_word = 1'b1;
			end
			CMD_MODULE_ID: begin
				word    = id;
				is_word = 1'b1;
			end
			default: ok = 1'b0;
		endcase
		if (is_word) begin
			val = (idx == 2'h0) ? word[7:0] : ((idx == 2'h1) ? word[15:8] : READ_FILL);
		end else if (idx != 2'h0) begin
			val = READ_FILL;
		end
		return {ok, val};
	endfunction : read_byte

	// ------------------------------------------------------------------
	// Serial transfer engine
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE} xfer_e;

	xfer_e      st_q, st_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	logic [2:0] byte_n_q, byte_n_d;
	logic [7:0] cmd_q, cmd_d;
	logic [7:0] data_q, data_d;
	logic       rd_q, rd_d;
	logic       is_addr_q, is_addr_d;
	logic [1:0] idx_q, idx_d;
	logic       nack_q, nack_d;
	logic       sda_oe_q, sda_oe_d;
	logic       crc_clr;
	logic       crc_shift;
	logic       exec;
	logic       rd_bad;
	logic [7:0] crc;
	logic [7:0] run_q, cfg_q, iout_q, temp_q, cml_q;
	logic [15:0] id_word;
	logic [1:0] idx_nx;
	logic [8:0] rd_first;
	logic [8:0] rd_next;

	assign idx_nx   = (idx_q == 2'h3) ? idx_q : idx_q + 2'h1;
	assign rd_first = read_byte(cmd_q, 2'h0, run_q, cfg_q, iout_q, temp_q, cml_q, id_word);
	assign rd_next  = read_byte(cmd_q, idx_nx, run_q, cfg_q, iout_q, temp_q, cml_q, id_word);

	always_comb begin
		st_d      = st_q;
		bit_cnt_d = bit_cnt_q;
		shift_d   = shift_q;
		byte_n_d  = byte_n_q;
		cmd_d     = cmd_q;
		data_d    = data_q;
		rd_d      = rd_q;
		is_addr_d = is_addr_q;
		idx_d     = idx_q;
		nack_d    = nack_q;
		sda_oe_d  = sda_oe_q;
		crc_clr   = 1'b0;
		crc_shift = 1'b0;
		exec      = 1'b0;
		rd_bad    = 1'b0;
		if (bus_stop) begin
			st_d     = ST_IDLE;
			sda_oe_d = 1'b0;
			exec     = !rd_q && (byte_n_q != 3'h0) && (st_q != ST_IDLE);
		end else if (bus_start) begin
			st_d      = ST_RX;
			bit_cnt_d = 4'h0;
			is_addr_d = 1'b1;
			sda_oe_d  = 1'b0;
			crc_clr   = 1'b1;
			if (st_q == ST_IDLE) begin
				byte_n_d = 3'h0;
				rd_d     = 1'b0;
			end
		end else begin
			case (st_q)
				ST_RX: begin
					if (scl_rise) begin
						shift_d   = {shift_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 4'h1;
						crc_shift = 1'b1; // RULE4
					end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
						if (is_addr_q) begin
							if (shift_q[7:1] == BUS_ADDR) begin
								st_d     = ST_RX_ACK;
								sda_oe_d = 1'b1;
								rd_d     = shift_q[0];
							end else begin
								st_d = ST_IGNORE;
							end
						end else begin
							st_d     = ST_RX_ACK;
							sda_oe_d = 1'b1;
							if (byte_n_q == 3'h0) begin
								cmd_d = shift_q;
							end
							if (byte_n_q == 3'h1) begin
								data_d = shift_q;
							end
							if (byte_n_q != BYTE_N_MAX) begin
								byte_n_d = byte_n_q + 3'h1;
							end
						end
					end
				end
				ST_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_d = 4'h0;
						is_addr_d = 1'b0;
						if (rd_q) begin
							st_d     = ST_TX;
							idx_d    = 2'h0;
							shift_d  = rd_first[7:0];
							sda_oe_d = ~rd_first[7];
							rd_bad   = ~rd_first[8]; // RULE3
						end else begin
							st_d     = ST_RX;
							sda_oe_d = 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						bit_cnt_d = bit_cnt_q + 4'h1;
						shift_d   = {shift_q[6:0], 1'b1};
						if (bit_cnt_q == BYTE_BITS - 4'h1) begin
							st_d     = ST_TX_ACK;
							sda_oe_d = 1'b0;
						end else begin
							sda_oe_d = ~shift_q[6];
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						nack_d = sda_s;
					end else if (scl_fall) begin
						if (!nack_q) begin
							st_d      = ST_TX;
							bit_cnt_d = 4'h0;
							idx_d     = idx_nx;
							shift_d   = rd_next[7:0];
							sda_oe_d  = ~rd_next[7];
						end else begin
							st_d = ST_IGNORE;
						end
					end
				end
				ST_IDLE, ST_IGNORE: begin
				end
				default: st_d = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			st_q      <= ST_IDLE;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			byte_n_q  <= 3'h0;
			cmd_q     <= 8'h00;
			data_q    <= 8'h00;
			rd_q      <= 1'b0;
			is_addr_q <= 1'b0;
			idx_q     <= 2'h0;
			nack_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
		end else begin
			st_q      <= st_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q   <= shift_d;
			byte_n_q  <= byte_n_d;
			cmd_q     <= cmd_d;
			data_q    <= data_d;
			rd_q      <= rd_d;
			is_addr_q <= is_addr_d;
			idx_q     <= idx_d;
			nack_q    <= nack_d;
			sda_oe_q  <= sda_oe_d;
		end
	end

	pec_crc8 u_pec (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RST_N),
		.i_clear (crc_clr),
		.i_shift (crc_shift),
		.i_bit   (sda_s),
		.o_crc   (crc)
	);

	// ------------------------------------------------------------------
	// Command execution and register state
	// ------------------------------------------------------------------
	logic [2:0] exp_len;
	logic       known;
	logic       do_it, pec_bad, bad_cmd, other_err;
	logic       wr_run, wr_cfg, clr;
	logic [7:0] iout_set, temp_set, cml_set;
	logic [7:0] run_d, cfg_d, iout_d, temp_d, cml_d;
	logic       alert_q, alert_d, en_q, en_d, pin_on;
	logic [5:0] rev_q, rev_d;
	logic [1:0] cap_q, cap_d;

	always_comb begin
		known   = 1'b1;
		exp_len = LEN_BYTE_WRITE;
		case (cmd_q)
			CMD_RUN_CTRL, CMD_ENABLE_CFG: exp_len = LEN_BYTE_WRITE; // RULE10 RULE11
			CMD_FAULT_CLEAR:              exp_len = LEN_SEND_BYTE;
			default:                      known = 1'b0;
		endcase
		do_it     = exec && known && ((byte_n_q == exp_len)
		          || (byte_n_q == exp_len + 3'h1 && crc == 8'h00));
		pec_bad   = exec && known && byte_n_q == exp_len + 3'h1 && crc != 8'h00; // RULE4
		bad_cmd   = (exec && !known) || rd_bad; // RULE3
		other_err = exec && known && byte_n_q != exp_len && byte_n_q != exp_len + 3'h1;
		wr_run    = do_it && cmd_q == CMD_RUN_CTRL;
		wr_cfg    = do_it && cmd_q == CMD_ENABLE_CFG;
		clr       = do_it && cmd_q == CMD_FAULT_CLEAR; // RULE13
		iout_set  = ({8{flt_s.oc_fault}} & IOUT_OC_FAULT_M)
		          | ({8{flt_s.oc_warn}} & IOUT_OC_WARN_M); // RULE1 RULE12
		temp_set  = ({8{flt_s.ot_fault}} & TEMP_OT_FAULT_M)
		          | ({8{flt_s.ot_warn}} & TEMP_OT_WARN_M); // RULE2
		cml_set   = ({8{bad_cmd}} & (CML_BAD_CMD_M | CML_BAD_DATA_M))
		          | ({8{pec_bad}} & CML_PEC_M) | ({8{other_err}} & CML_OTHER_M); // RULE3 RULE4
		// Set wins over a simultaneous clear; undefined bits masked off
		iout_d    = (clr ? iout_set : iout_q | iout_set) & IOUT_MASK; // RULE13 RULE14
		temp_d    = (clr ? temp_set : temp_q | temp_set) & TEMP_MASK; // RULE13 RULE14
		cml_d     = (clr ? cml_set : cml_q | cml_set) & CML_MASK; // RULE13 RULE14
		run_d     = wr_run ? ((data_q & RUN_CTRL_WMASK) | (run_q & ~RUN_CTRL_WMASK)) : run_q;
		cfg_d     = wr_cfg ? ((data_q & EN_CFG_WMASK) | (cfg_q & ~EN_CFG_WMASK)) : cfg_q;
		alert_d   = |(iout_d | temp_d | cml_d); // RULE13
		pin_on    = cfg_q[ENC_POL_BIT] ? pin_s : ~pin_s;
		en_d      = !cfg_q[ENC_PU_BIT] || ((!cfg_q[ENC_CMD_BIT] || run_q[RUN_ON_BIT])
		          && (!cfg_q[ENC_CPR_BIT] || pin_on)); // RULE11
		cap_d     = (cap_q == 2'h3) ? cap_q : cap_q + 2'h1;
		rev_d     = (cap_q == CAP_DLY) ? rev_s : rev_q; // RULE9
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			run_q   <= RUN_CTRL_RST;
			cfg_q   <= EN_CFG_RST;
			iout_q  <= STATUS_RST;
			temp_q  <= STATUS_RST;
			cml_q   <= STATUS_RST;
			alert_q <= 1'b0;
			en_q    <= 1'b0;
			cap_q   <= 2'h0;
			rev_q   <= 6'h00;
		end else begin
			run_q   <= run_d;
			cfg_q   <= cfg_d;
			iout_q  <= iout_d;
			temp_q  <= temp_d;
			cml_q   <= cml_d;
			alert_q <= alert_d;
			en_q    <= en_d;
			cap_q   <= cap_d;
			rev_q   <= rev_d;
		end
	end

	assign id_word     = {rev_q, MFR_ID, MODULE_TYPE, ID_LOW_RSVD}; // RULE7 RULE8 RULE9
	assign O_SDA       = 1'b0;
	assign O_SDA_OE    = sda_oe_q;
	assign O_ALERT     = 1'b0;
	assign O_ALERT_OE  = alert_q;
	assign O_CTRL      = '{run_ctrl: run_q, en_cfg: cfg_q};
	assign O_OUTPUT_EN = en_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	chk_oc_fault_flag: assert property (flt_s.oc_fault |=> iout_q[7] && alert_q) // RULE1
		else $error("overcurrent fault not flagged");
	chk_ot_warn_flag: assert property (flt_s.ot_warn
		|=> temp_q[6] ##1 (temp_q[6] || $past(clr))) // RULE2
		else $error("overtemperature warning not held");
	chk_bad_cmd_flag: assert property (bad_cmd |=> cml_q[7] && cml_q[6]) // RULE3
		else $error("invalid command not flagged");
	chk_pec_fail_flag: assert property (pec_bad
		|=> cml_q[5] && $stable(run_q) && $stable(cfg_q)) // RULE4
		else $error("packet check failure not flagged");
	chk_vin_floor_lo: assert property (st_q == ST_RX_ACK && rd_q && scl_fall && !bus_stop
		&& !bus_start && cmd_q == CMD_VIN_FLOOR |=> shift_q == 8'h0C) // RULE5
		else $error("input floor low byte wrong");
	chk_id_low_byte: assert property (id_word[1:0] == 2'h2 && id_word[7:2] == MODULE_TYPE) // RULE7
		else $error("identification low byte wrong");
	chk_run_write: assert property (wr_run |=> run_q == ((run_q & RUN_CTRL_WMASK)
		| RUN_CTRL_RST) && run_q == ($past(data_q) & RUN_CTRL_WMASK)) // RULE10
		else $error("run control write lost");
	chk_enable_out: assert property (!cfg_q[ENC_PU_BIT] |=> O_OUTPUT_EN) // RULE11
		else $error("output not enabled while pin and bus ignored");
	chk_clear_release: assert property (clr && !(|{flt_s, bad_cmd, pec_bad})
		|=> iout_q == 8'h00 && cml_q == 8'h00 && !O_ALERT_OE) // RULE13
		else $error("clear did not release alert");
	chk_rsvd_zero: assert property ((iout_q & ~IOUT_MASK) == 8'h00
		&& (temp_q & ~TEMP_MASK) == 8'h00 && (cml_q & ~CML_MASK) == 8'h00) // RULE14
		else $error("undefined status bit set");

	cov_run_write:  cover property (wr_run);
	cov_pec_fail:   cover property (pec_bad);
	cov_word_read:  cover property (st_q == ST_TX && idx_q == 2'h1 && cmd_q == CMD_MODULE_ID);
	cov_clear_flt:  cover property (clr && alert_q);
endmodule : power_module_status_regs

/* dv/pmbus_host_model.sv */
// Host model driving the serial management bus clock and data lines
`timescale 1ns/1ps
module pmbus_host_model (
	input  wire logic i_dev_sda_oe,
	output logic      o_scl,
	output logic      o_sda
);
	logic m_oe;

	// Open-drain data line with pull-up
	assign o_sda = !m_oe && !i_dev_sda_oe;

	initial begin
		o_scl = 1'b1;
		m_oe  = 1'b0;
	end

	// ----------------------------------------------------------------
	// Bit level, clock stands high outside frames
	// ----------------------------------------------------------------
	task automatic bit_x(input logic b, output logic r);
		m_oe = !b;
		#40 o_scl = 1'b1;
		#40 r = o_sda;
		#40 o_scl = 1'b0;
		#40;
	endtask : bit_x

	task automatic start();
		m_oe = 1'b0;
		#40 o_scl = 1'b1;
		#80 m_oe = 1'b1;
		#80 o_scl = 1'b0;
		#40;
	endtask : start

	task automatic stop();
		m_oe = 1'b1;
		#40 o_scl = 1'b1;
		#80 m_oe = 1'b0;
		#80;
	endtask : stop

	task automatic put(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(b[i], r);
		bit_x(1'b1, r);
		ack = !r;
	endtask : put

	task automatic get(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			b[i] = r;
		end
		bit_x(last, r);
	endtask : get

	// ----------------------------------------------------------------
	// Transactions to bus address 0x40, data low byte first
	// ----------------------------------------------------------------
	task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int nd);
		logic a;
		start();
		put(8'h80, a);
		put(cmd, a);
		for (int i = 0; i < nd; i++) put(d[8*i +: 8], a);
		stop();
	endtask : wr

	task automatic rd(input logic [7:0] cmd, input int n, output logic [15:0] v);
		logic a;
		v = 16'h0000;
		start();
		put(8'h80, a);
		put(cmd, a);
		start();
		put(8'h81, a);
		for (int i = 0; i < n; i++) get(i == n - 1, v[8*i +: 8]);
		stop();
	endtask : rd
endmodule : pmbus_host_model

/* dv/power_module_status_regs_bench.sv */
// Self-checking bench for the status register block
`timescale 1ns/1ps
module power_module_status_regs_bench;
	import pmod_status_pkg::*;

	localparam logic [5:0] TYPE_CODE = 6'h0B; // Arbitrary value
	localparam logic [1:0] MAKER_ID  = 2'h1;  // Arbitrary value
	localparam logic [5:0] REV       = 6'h15;

	logic        clk;
	logic        rst_n;
	logic        scl;
	logic        sda;
	logic        pin;
	logic        sda_oe;
	logic        alert;
	logic        output_en;
	logic        sda_dat;
	logic        alert_dat;
	fault_in_s   faults;
	ctrl_out_s   ctrl;
	logic [15:0] v;
	int          n_errors = 0;
	int          compares = 0;
	int          cycles   = 0;

	power_module_status_regs #(.MODULE_TYPE(TYPE_CODE), .MFR_ID(MAKER_ID))
	power_module_status_regs_i (
		.I_REF_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl), .I_SDA(sda),
		.I_ONOFF_PIN(pin), .I_FAULTS(faults), .I_MODULE_REV(REV),
		.O_SDA(sda_dat), .O_SDA_OE(sda_oe), .O_ALERT(alert_dat), .O_ALERT_OE(alert),
		.O_CTRL(ctrl), .O_OUTPUT_EN(output_en)
	);

	pmbus_host_model pmbus_host_model_i (.i_dev_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 80000) begin
			n_errors++;
			finish_test();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	function automatic logic [7:0] crc(input logic [23:0] d);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 23; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
		return c;
	endfunction : crc

	task automatic clr();
		pmbus_host_model_i.wr(CMD_FAULT_CLEAR, 16'h0000, 0);
	endtask : clr

	task automatic ctrl_case(input logic [7:0] cmd, input logic [7:0] d, input logic p,
			input logic [15:0] ectrl, input logic een);
		pin = p;
		pmbus_host_model_i.wr(cmd, 16'(d), 1);
		check("ctrl", 16'(ctrl), ectrl);
		check("enable", 16'(output_en), 16'(een));
		pmbus_host_model_i.rd(cmd, 1, v);
		check("readback", v, 16'(cmd == CMD_RUN_CTRL ? ectrl[15:8] : ectrl[7:0]));
	endtask : ctrl_case

	task automatic comm_case(input logic [7:0] cmd, input logic [15:0] d, input int nd,
			input logic [7:0] ecml, input logic [15:0] ectrl);
		pmbus_host_model_i.wr(cmd, d, nd);
		pmbus_host_model_i.rd(CMD_COMM_STATUS, 1, v);
		check("comm status", v, 16'(ecml));
		check("ctrl", 16'(ctrl), ectrl);
		clr();
	endtask : comm_case

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] cmds[3] = '{CMD_CURRENT_STATUS, CMD_THERMAL_STATUS, CMD_COMM_STATUS};
		check("ctrl reset", 16'(ctrl), 16'h0017);
		check("enable reset", 16'(output_en), 16'h0001);
		check("sda level", 16'(sda_dat), 16'h0000);
		check("alert level", 16'(alert_dat), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			pmbus_host_model_i.rd(cmds[i], 1, v);
			check("status reset", v, 16'h0000);
		end
	endtask : t_reset

	task automatic t_words();
		pmbus_host_model_i.rd(CMD_VIN_FLOOR, 2, v);
		check("vin floor", v, {5'h1E, 11'h00C});
		pmbus_host_model_i.rd(CMD_VOUT_FLOOR, 2, v);
		check("vout floor", v, {5'h16, 11'h266});
		pmbus_host_model_i.rd(CMD_MODULE_ID, 2, v);
		check("id type", 16'(v[7:0]), 16'({TYPE_CODE, 2'h2}));
		check("id maker", 16'(v[9:8]), 16'(MAKER_ID));
		check("id rev", 16'(v[15:10]), 16'(REV));
	endtask : t_words

	task automatic t_faults();
		logic [7:0] cmd[4] = '{CMD_CURRENT_STATUS, CMD_CURRENT_STATUS,
			CMD_THERMAL_STATUS, CMD_THERMAL_STATUS};
		logic [7:0] exp[4] = '{8'h80, 8'h20, 8'h80, 8'h40};
		for (int i = 0; i < 5; i++) begin
			faults = (i == 4) ? fault_in_s'(4'hF) : fault_in_s'(4'h8 >> i);
			repeat (6) @(negedge clk);
			faults = fault_in_s'(4'h0);
			repeat (6) @(negedge clk);
			check("alert", 16'(alert), 16'h0001);
			if (i == 4) begin
				pmbus_host_model_i.rd(CMD_CURRENT_STATUS, 1, v);
				check("all current", v, 16'h00A0);
				pmbus_host_model_i.rd(CMD_THERMAL_STATUS, 1, v);
				check("all thermal", v, 16'h00C0);
			end else begin
				pmbus_host_model_i.rd(cmd[i], 1, v);
				check("flag", v, 16'(exp[i]));
			end
			clr();
			check("alert clear", 16'(alert), 16'h0000);
			pmbus_host_model_i.rd(cmd[i % 4], 1, v);
			check("flag clear", v, 16'h0000);
		end
	endtask : t_faults

	task automatic t_ctrl();
		ctrl_case(CMD_RUN_CTRL, 8'hFF, 1'b1, 16'hBC17, 1'b1);
		ctrl_case(CMD_ENABLE_CFG, 8'h00, 1'b0, 16'hBC01, 1'b1);
		ctrl_case(CMD_ENABLE_CFG, 8'h18, 1'b0, 16'hBC19, 1'b1);
		ctrl_case(CMD_RUN_CTRL, 8'h00, 1'b0, 16'h0019, 1'b0);
		ctrl_case(CMD_ENABLE_CFG, 8'h16, 1'b0, 16'h0017, 1'b0);
		ctrl_case(CMD_ENABLE_CFG, 8'h16, 1'b1, 16'h0017, 1'b1);
		ctrl_case(CMD_ENABLE_CFG, 8'h14, 1'b0, 16'h0015, 1'b1);
		ctrl_case(CMD_ENABLE_CFG, 8'h14, 1'b1, 16'h0015, 1'b0);
		ctrl_case(CMD_ENABLE_CFG, 8'h16, 1'b1, 16'h0017, 1'b1);
	endtask : t_ctrl

	task automatic t_comm();
		logic [7:0] pec;
		pec = crc({8'h80, CMD_RUN_CTRL, 8'h80});
		comm_case(8'h55, 16'h00AA, 1, 8'hC0, 16'h0017);
		pmbus_host_model_i.wr(CMD_CURRENT_STATUS, 16'h00FF, 1);
		pmbus_host_model_i.rd(CMD_CURRENT_STATUS, 1, v);
		check("status write", v, 16'h0000);
		comm_case(CMD_CURRENT_STATUS, 16'h00FF, 1, 8'hC0, 16'h0017);
		comm_case(CMD_RUN_CTRL, 16'h0000, 0, 8'h02, 16'h0017);
		comm_case(CMD_RUN_CTRL, {~pec, 8'h80}, 2, 8'h20, 16'h0017);
		comm_case(CMD_RUN_CTRL, {pec, 8'h80}, 2, 8'h00, 16'h8017);
		pmbus_host_model_i.rd(8'h55, 1, v);
		check("bad read", v, 16'h00FF);
		pmbus_host_model_i.rd(CMD_COMM_STATUS, 1, v);
		check("bad read flag", v, 16'h00C0);
		clr();
	endtask : t_comm

	task automatic finish_test();
		$display("Compares %0d, errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	initial begin
		rst_n  = 1'b0;
		pin    = 1'b1;
		faults = fault_in_s'(4'h0);
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		repeat (8) @(negedge clk);
		t_reset();
		t_words();
		t_faults();
		t_ctrl();
		t_comm();
		finish_test();
	end
endmodule : power_module_status_regs_bench
